/* File: copper_phy_mgmt_registers.sv */
// Management register bank of the tri-speed copper PHY with sync clock steering
module copper_phy_mgmt_registers #(
  parameter logic [15:0] ID_HIGH  = 16'h1234, // Arbitrary value
  parameter logic [5:0]  ID_ORG   = 6'h2A,    // Arbitrary value
  parameter logic [5:0]  ID_MODEL = 6'h15,    // Arbitrary value
  parameter logic [3:0]  ID_REV   = 4'h3      // Arbitrary value
) (
  input  wire logic                       mclk_in,
  input  wire logic                       sys_rst_in,
  input  wire logic                       ce_in,
  input  wire phy_mgmt_pkg::reg_req_t     reg_req_in,
  output logic [15:0]                     reg_rdata_out,
  output logic                            reg_rvalid_out,
  input  wire logic                       cfg_wr_in,
  input  wire logic [7:0]                 cfg_byte_in,
  output logic [7:0]                      cfg_byte_out,
  input  wire phy_mgmt_pkg::phy_status_t  status_in,
  output phy_mgmt_pkg::phy_control_t      control_out,
  output phy_mgmt_pkg::clock_steer_t      clock_steer_out
);

  // Whole state of the bank
  typedef struct packed {
    logic [15:0] control;
    logic [15:0] advertise;
    logic [15:0] np_transmit;
    logic [15:0] gig_control;
    logic [15:0] partner_ability;
    logic [15:0] partner_next_page;
    logic [15:0] recov_sel;
    logic [15:0] recov_shadow;
    logic [7:0]  idle_count;
    logic        page_received;
    logic        restart_pulse;
    logic        reset_pulse;
    logic [7:0]  cfg_byte;
    logic [15:0] rdata;
    logic        rvalid;
  } bank_state_t;

  bank_state_t state;
  bank_state_t next_state;

  // Speed and duplex to the auxiliary code
  function automatic logic [2:0] speed_code(input phy_mgmt_pkg::phy_status_t s);
    logic [2:0] code;
    code = phy_mgmt_pkg::SPD_NO_LINK;
    if (s.link_up) begin
      case (s.speed)
        phy_mgmt_pkg::SPEED_10: begin
          code = s.full_duplex ? phy_mgmt_pkg::SPD_10_FULL : phy_mgmt_pkg::SPD_10_HALF;
        end
        phy_mgmt_pkg::SPEED_100: begin
          code = s.full_duplex ? phy_mgmt_pkg::SPD_100_FULL : phy_mgmt_pkg::SPD_100_HALF;
        end
        phy_mgmt_pkg::SPEED_1000: begin
          code = phy_mgmt_pkg::SPD_1000_FULL;
        end
        default: begin
          code = phy_mgmt_pkg::SPD_NO_LINK;
        end
      endcase
    end
    return code;
  endfunction

  // Write hit on a given address
  function automatic logic wr_hit(input phy_mgmt_pkg::reg_req_t r, input logic [4:0] a);
    return r.wr && (r.addr == a);
  endfunction

  logic [2:0]  aux_speed;
  logic        loc_pause;
  logic        loc_asym;
  logic        lp_pause;
  logic        lp_asym;
  logic        rx_pause;
  logic        tx_pause;
  logic        gig_slave_link;
  logic [15:0] basic_status;
  logic [15:0] id_low;
  logic [15:0] expansion;
  logic [15:0] gig_status;
  logic [15:0] aux_status;
  logic [15:0] read_mux;
  logic [15:0] ctl_written;
  logic [7:0]  idle_base;

  // Pause resolution, valid only for a full duplex link
  assign loc_pause = state.advertise[phy_mgmt_pkg::ADV_PAUSE];
  assign loc_asym  = state.advertise[phy_mgmt_pkg::ADV_ASYM_PAUSE];
  assign lp_pause  = state.partner_ability[phy_mgmt_pkg::ADV_PAUSE];
  assign lp_asym   = state.partner_ability[phy_mgmt_pkg::ADV_ASYM_PAUSE];
  assign rx_pause  = status_in.link_up && status_in.full_duplex &&
                     loc_pause && (lp_pause || (loc_asym && lp_asym));
  assign tx_pause  = status_in.link_up && status_in.full_duplex &&
                     lp_pause && (loc_pause || (loc_asym && lp_asym));
  assign aux_speed = speed_code(status_in);

  // Read views built from live status and stored fields
  assign basic_status = phy_mgmt_pkg::BASIC_STATUS_FIXED |
                        {10'h000, status_in.an_complete, status_in.remote_fault, 1'b0,
                         status_in.link_up, status_in.jabber, 1'b0};
  assign id_low       = {ID_ORG, ID_MODEL, ID_REV};
  assign expansion    = phy_mgmt_pkg::EXPANSION_FIXED |
                        {11'h000, status_in.par_det_fault,
                         state.partner_ability[phy_mgmt_pkg::ADV_NEXT_PAGE], 1'b0,
                         state.page_received, status_in.partner_an_able};
  assign gig_status   = {status_in.ms_fault, status_in.master_resolved,
                         status_in.local_rx_ok, status_in.remote_rx_ok,
                         status_in.partner_gig_full_ability,
                         status_in.partner_gig_half_ability, 2'h0,
                         state.idle_count};
  assign aux_status   = {status_in.an_complete, 4'h0, aux_speed, status_in.par_det_fault,
                         state.partner_ability[13], state.page_received,
                         status_in.partner_an_able,
                         state.partner_ability[phy_mgmt_pkg::ADV_NEXT_PAGE],
                         status_in.link_up, rx_pause, tx_pause};

  // Read decode; unmapped addresses read zero
  always_comb begin
    case (reg_req_in.addr)
      phy_mgmt_pkg::ADDR_CONTROL:      read_mux = state.control;
      phy_mgmt_pkg::ADDR_BASIC_STATUS: read_mux = basic_status;
      phy_mgmt_pkg::ADDR_ID_HIGH:      read_mux = ID_HIGH;
      phy_mgmt_pkg::ADDR_ID_LOW:       read_mux = id_low;
      phy_mgmt_pkg::ADDR_ADVERTISE:    read_mux = state.advertise;
      phy_mgmt_pkg::ADDR_PARTNER:      read_mux = state.partner_ability;
      phy_mgmt_pkg::ADDR_EXPANSION:    read_mux = expansion;
      phy_mgmt_pkg::ADDR_NP_TRANSMIT:  read_mux = state.np_transmit;
      phy_mgmt_pkg::ADDR_PARTNER_NP:   read_mux = state.partner_next_page;
      phy_mgmt_pkg::ADDR_GIG_CONTROL:  read_mux = state.gig_control;
      phy_mgmt_pkg::ADDR_GIG_STATUS:   read_mux = gig_status;
      phy_mgmt_pkg::ADDR_EXT_STATUS:   read_mux = phy_mgmt_pkg::EXT_STATUS_VALUE;
      phy_mgmt_pkg::ADDR_RECOV_SEL:    read_mux = state.recov_sel;
      phy_mgmt_pkg::ADDR_RECOV_SHADOW: read_mux = state.recov_shadow;
      phy_mgmt_pkg::ADDR_AUX_STATUS:   read_mux = aux_status;
      default:                         read_mux = 16'h0000;
    endcase
  end

  // Control write value; self-clearing bits never stored
  assign ctl_written = reg_req_in.wdata &
                       ~(16'h0001 << phy_mgmt_pkg::CTL_AN_RESTART) &
                       ~(16'h0001 << phy_mgmt_pkg::CTL_SOFT_RESET);

  // Next state of the whole bank
  always_comb begin
    next_state = state;
    next_state.restart_pulse = 1'b0;
    next_state.reset_pulse   = 1'b0;
    next_state.rvalid        = reg_req_in.rd;
    if (reg_req_in.rd) begin
      next_state.rdata = read_mux;
    end

    // Idle error count: cleared by its read, a same-cycle error still counts
    idle_base = (reg_req_in.rd && reg_req_in.addr == phy_mgmt_pkg::ADDR_GIG_STATUS)
                ? 8'h00 : state.idle_count;
    if (status_in.idle_error && idle_base != phy_mgmt_pkg::IDLE_COUNT_MAX) begin
      next_state.idle_count = idle_base + 8'h01;
    end else begin
      next_state.idle_count = idle_base;
    end

    // Page received latch: read of expansion clears, new page wins
    if (reg_req_in.rd && reg_req_in.addr == phy_mgmt_pkg::ADDR_EXPANSION) begin
      next_state.page_received = 1'b0;
    end
    if (status_in.base_page_valid) begin
      next_state.partner_ability = status_in.base_page;
      next_state.page_received   = 1'b1;
    end
    if (status_in.next_page_valid) begin
      next_state.partner_next_page = status_in.next_page;
      next_state.page_received     = 1'b1;
    end

    // Toggle flips with each next page sent
    if (status_in.next_page_sent) begin
      next_state.np_transmit[phy_mgmt_pkg::NP_TOGGLE] =
        ~state.np_transmit[phy_mgmt_pkg::NP_TOGGLE];
    end

    // Register writes; read-only addresses ignore writes
    if (wr_hit(reg_req_in, phy_mgmt_pkg::ADDR_CONTROL)) begin
      next_state.control = ctl_written;
      next_state.restart_pulse = reg_req_in.wdata[phy_mgmt_pkg::CTL_AN_RESTART] &&
                                 reg_req_in.wdata[phy_mgmt_pkg::CTL_AN_ENABLE];
      next_state.reset_pulse = reg_req_in.wdata[phy_mgmt_pkg::CTL_SOFT_RESET];
    end
    if (wr_hit(reg_req_in, phy_mgmt_pkg::ADDR_ADVERTISE)) begin
      next_state.advertise = reg_req_in.wdata & phy_mgmt_pkg::ADVERTISE_WMASK;
    end
    if (wr_hit(reg_req_in, phy_mgmt_pkg::ADDR_NP_TRANSMIT)) begin
      next_state.np_transmit = (reg_req_in.wdata & phy_mgmt_pkg::NP_TRANSMIT_WMASK) |
        (next_state.np_transmit & ~phy_mgmt_pkg::NP_TRANSMIT_WMASK);
    end
    if (wr_hit(reg_req_in, phy_mgmt_pkg::ADDR_GIG_CONTROL)) begin
      next_state.gig_control = reg_req_in.wdata & phy_mgmt_pkg::GIG_CONTROL_WMASK;
    end
    if (wr_hit(reg_req_in, phy_mgmt_pkg::ADDR_RECOV_SEL)) begin
      next_state.recov_sel = reg_req_in.wdata;
    end
    if (wr_hit(reg_req_in, phy_mgmt_pkg::ADDR_RECOV_SHADOW)) begin
      next_state.recov_shadow = reg_req_in.wdata;
    end

    // Config byte: top bit may only hold one
    if (cfg_wr_in) begin
      next_state.cfg_byte = cfg_byte_in | phy_mgmt_pkg::CFG_FORCED_ONES;
    end

    // Software reset restores all but the recovery registers and config byte to default
    if (state.reset_pulse) begin
      next_state.control           = phy_mgmt_pkg::RST_CONTROL;
      next_state.advertise         = phy_mgmt_pkg::RST_ADVERTISE;
      next_state.np_transmit       = phy_mgmt_pkg::RST_NP_TRANSMIT;
      next_state.gig_control       = phy_mgmt_pkg::RST_GIG_CONTROL;
      next_state.partner_ability   = 16'h0000;
      next_state.partner_next_page = 16'h0000;
      next_state.idle_count        = 8'h00;
      next_state.page_received     = 1'b0;
    end
  end

  // State register, frozen while clock enable is low
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state                   <= '0;
      state.control           <= phy_mgmt_pkg::RST_CONTROL;
      state.advertise         <= phy_mgmt_pkg::RST_ADVERTISE;
      state.np_transmit       <= phy_mgmt_pkg::RST_NP_TRANSMIT;
      state.gig_control       <= phy_mgmt_pkg::RST_GIG_CONTROL;
      state.recov_sel         <= phy_mgmt_pkg::RST_RECOV_SEL;
      state.recov_shadow      <= phy_mgmt_pkg::RST_RECOV_SHADOW;
      state.cfg_byte          <= phy_mgmt_pkg::RST_CFG_BYTE;
    end else if (ce_in) begin
      state <= next_state;
    end
  end

  // Clock from the partner only on a gigabit slave link; 10 Mbit never qualifies
  assign gig_slave_link = status_in.link_up && status_in.speed == phy_mgmt_pkg::SPEED_1000 &&
                          !status_in.master_resolved;

  // Outputs to the PHY core and the clock pins
  always_comb begin
    control_out.soft_reset  = state.reset_pulse;
    control_out.an_restart  = state.restart_pulse;
    control_out.an_enable   = state.control[phy_mgmt_pkg::CTL_AN_ENABLE];
    control_out.role_manual = state.gig_control[phy_mgmt_pkg::GIG_MANUAL_EN];
    control_out.role_master = state.gig_control[phy_mgmt_pkg::GIG_MANUAL_EN] &&
                              state.gig_control[phy_mgmt_pkg::GIG_MANUAL_MST];
    control_out.multiport   = state.gig_control[phy_mgmt_pkg::GIG_MULTIPORT];
    // Reserved test codes fall back to normal so the line is never left odd
    if (state.gig_control[phy_mgmt_pkg::GIG_TEST_MSB] &&
        state.gig_control[14:phy_mgmt_pkg::GIG_TEST_LSB] != 2'h0) begin
      control_out.test_mode = phy_mgmt_pkg::TEST_NORMAL;
    end else begin
      control_out.test_mode = phy_mgmt_pkg::test_mode_t'(
        state.gig_control[phy_mgmt_pkg::GIG_TEST_MSB:phy_mgmt_pkg::GIG_TEST_LSB]);
    end
    control_out.rx_pause    = rx_pause;
    control_out.tx_pause    = tx_pause;
    clock_steer_out.prc_select       = ~state.cfg_byte[phy_mgmt_pkg::CFG_CLK_SOURCE];
    clock_steer_out.clock_out_enable = ~state.cfg_byte[phy_mgmt_pkg::CFG_CLK_OUT_DIS];
    clock_steer_out.from_partner     = gig_slave_link &&
                                       state.recov_sel[phy_mgmt_pkg::RECOV_ENABLE];
  end

  assign reg_rdata_out  = state.rdata;
  assign reg_rvalid_out = state.rvalid;
  assign cfg_byte_out   = state.cfg_byte;

endmodule

/* File: phy_host_model.sv */
// Host management controller driving the register and config byte ports
module phy_host_model (
  input  wire logic              mclk_in,
  input  wire logic [15:0]       reg_rdata_in,
  input  wire logic              reg_rvalid_in,
  output phy_mgmt_pkg::reg_req_t reg_req_out,
  output logic                   cfg_wr_out,
  output logic [7:0]             cfg_byte_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_req_out = '0;
    cfg_wr_out = 1'b0;
    cfg_byte_out = 8'h00;
  end
  // One-cycle write strobe; the unsupported four-pair bit is never set
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    reg_req_out <= '{1'b0, 1'b1, a, (a == 5'h04) ? (d & 16'hFDFF) : d};
    @(posedge mclk_in);
    reg_req_out.wr <= 1'b0;
  endtask
  // Answer comes one cycle after the read edge
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge mclk_in);
    reg_req_out <= '{1'b1, 1'b0, a, 16'h0000};
    @(posedge mclk_in);
    reg_req_out.rd <= 1'b0;
    #1;
    d = reg_rvalid_in ? reg_rdata_in : 16'hXXXX;
  endtask
  task automatic cfg(input logic [7:0] b);
    @(posedge mclk_in);
    cfg_wr_out <= 1'b1;
    cfg_byte_out <= b;
    @(posedge mclk_in);
    cfg_wr_out <= 1'b0;
  endtask
  // Reference clock in, manual master, restart negotiation
  task automatic sync_master();
    cfg(8'hFE);
    wr(5'h09, 16'h1A00);
    wr(5'h00, 16'h1340);
  endtask
  // Recovery on, clock output on, manual slave, restart negotiation
  task automatic sync_slave();
    wr(5'h17, 16'h0F44);
    wr(5'h15, 16'h0010);
    cfg(8'hBB);
    wr(5'h09, 16'h1200);
    wr(5'h00, 16'h1340);
  endtask
endmodule

/* File: phy_mgmt_checker.sv */
// Port-level properties of the PHY management register bank
module phy_mgmt_checker #(
  parameter logic [15:0] ID_HIGH = 16'h1234 // Arbitrary value
) (
  input wire logic                       mclk_in,
  input wire logic                       sys_rst_in,
  input wire logic                       ce_in,
  input wire phy_mgmt_pkg::reg_req_t     reg_req_in,
  input wire logic [15:0]                reg_rdata_out,
  input wire logic                       reg_rvalid_out,
  input wire logic                       cfg_wr_in,
  input wire logic [7:0]                 cfg_byte_in,
  input wire logic [7:0]                 cfg_byte_out,
  input wire phy_mgmt_pkg::phy_status_t  status_in,
  input wire phy_mgmt_pkg::phy_control_t control_out,
  input wire phy_mgmt_pkg::clock_steer_t clock_steer_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  phy_mgmt_pkg::phy_status_t st_q;
  wire rd = ce_in && reg_req_in.rd;
  // Status as seen at the read edge
  always_ff @(posedge mclk_in) begin
    st_q <= status_in;
  end
  function automatic logic [2:0] spd(phy_mgmt_pkg::phy_status_t s);
    if (!s.link_up) return 3'h0;
    if (s.speed == phy_mgmt_pkg::SPEED_1000) return 3'h7;
    return (s.speed == phy_mgmt_pkg::SPEED_100 ? 3'h3 : 3'h1) + {2'h0, s.full_duplex};
  endfunction
  property p_basic;
    rd && reg_req_in.addr == phy_mgmt_pkg::ADDR_BASIC_STATUS |=> reg_rvalid_out &&
      reg_rdata_out[5:0] == {st_q.an_complete, st_q.remote_fault, 1'b1, st_q.link_up,
      st_q.jabber, 1'b1};
  endproperty
  a_basic: assert property (p_basic) else $error("basic status mismatch");
  property p_id;
    rd && reg_req_in.addr == phy_mgmt_pkg::ADDR_ID_HIGH |=> reg_rdata_out == ID_HIGH;
  endproperty
  a_id: assert property (p_id) else $error("identifier mismatch");
  property p_adv;
    rd && reg_req_in.addr == phy_mgmt_pkg::ADDR_ADVERTISE |=> !reg_rdata_out[9];
  endproperty
  a_adv: assert property (p_adv) else $error("advertise bit 9 set");
  property p_gig;
    rd && reg_req_in.addr == phy_mgmt_pkg::ADDR_GIG_STATUS |=> reg_rdata_out[15:10] ==
      {st_q.ms_fault, st_q.master_resolved, st_q.local_rx_ok, st_q.remote_rx_ok,
      st_q.partner_gig_full_ability, st_q.partner_gig_half_ability};
  endproperty
  a_gig: assert property (p_gig) else $error("gigabit status mismatch");
  property p_ext;
    rd && reg_req_in.addr == phy_mgmt_pkg::ADDR_EXT_STATUS |=> reg_rdata_out == 16'h3000;
  endproperty
  a_ext: assert property (p_ext) else $error("extended status mismatch");
  property p_aux;
    rd && reg_req_in.addr == phy_mgmt_pkg::ADDR_AUX_STATUS |=> reg_rdata_out[10:8] ==
      spd(st_q) && reg_rdata_out[15] == st_q.an_complete && reg_rdata_out[2] == st_q.link_up;
  endproperty
  a_aux: assert property (p_aux) else $error("auxiliary status mismatch");
  property p_restart;
    ce_in && reg_req_in.wr && reg_req_in.addr == phy_mgmt_pkg::ADDR_CONTROL &&
      reg_req_in.wdata[9] && reg_req_in.wdata[12] |=> control_out.an_restart ##1
      !control_out.an_restart;
  endproperty
  a_restart: assert property (p_restart) else $error("restart pulse wrong");
  property p_steer;
    clock_steer_out.from_partner |-> status_in.link_up && !status_in.master_resolved &&
      status_in.speed == phy_mgmt_pkg::SPEED_1000;
  endproperty
  a_steer: assert property (p_steer) else $error("clock taken from partner");
  property p_cfg;
    ce_in && cfg_wr_in |=> cfg_byte_out == ($past(cfg_byte_in) | 8'h80) &&
      clock_steer_out.prc_select == !cfg_byte_out[0] &&
      clock_steer_out.clock_out_enable == !cfg_byte_out[2];
  endproperty
  a_cfg: assert property (p_cfg) else $error("config byte mismatch");
  c_restart: cover property (control_out.an_restart);
  c_partner: cover property (clock_steer_out.from_partner);
  c_cfg: cover property (ce_in && cfg_wr_in);
endmodule
bind copper_phy_mgmt_registers phy_mgmt_checker #(.ID_HIGH(ID_HIGH)) i_checker (
  .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in), .reg_req_in(reg_req_in),
  .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out), .cfg_wr_in(cfg_wr_in),
  .cfg_byte_in(cfg_byte_in), .cfg_byte_out(cfg_byte_out), .status_in(status_in),
  .control_out(control_out), .clock_steer_out(clock_steer_out));

/* File: phy_mgmt_pkg.sv */
// Shared constants and carrier types for the copper PHY management register bank
package phy_mgmt_pkg;

  // Register addresses on the management port
  localparam logic [4:0] ADDR_CONTROL      = 5'h00;
  localparam logic [4:0] ADDR_BASIC_STATUS = 5'h01;
  localparam logic [4:0] ADDR_ID_HIGH      = 5'h02;
  localparam logic [4:0] ADDR_ID_LOW       = 5'h03;
  localparam logic [4:0] ADDR_ADVERTISE    = 5'h04;
  localparam logic [4:0] ADDR_PARTNER      = 5'h05;
  localparam logic [4:0] ADDR_EXPANSION    = 5'h06;
  localparam logic [4:0] ADDR_NP_TRANSMIT  = 5'h07;
  localparam logic [4:0] ADDR_PARTNER_NP   = 5'h08;
  localparam logic [4:0] ADDR_GIG_CONTROL  = 5'h09;
  localparam logic [4:0] ADDR_GIG_STATUS   = 5'h0A;
  localparam logic [4:0] ADDR_EXT_STATUS   = 5'h0F;
  localparam logic [4:0] ADDR_RECOV_SEL    = 5'h15;
  localparam logic [4:0] ADDR_RECOV_SHADOW = 5'h17;
  localparam logic [4:0] ADDR_AUX_STATUS   = 5'h19;

  // Reset values
  localparam logic [15:0] RST_CONTROL      = 16'h1140;
  localparam logic [15:0] RST_ADVERTISE    = 16'h01E1;
  localparam logic [15:0] RST_NP_TRANSMIT  = 16'h2001;
  localparam logic [15:0] RST_GIG_CONTROL  = 16'h0200;
  localparam logic [15:0] RST_RECOV_SEL    = 16'h0000;
  localparam logic [15:0] RST_RECOV_SHADOW = 16'h0F44;
  localparam logic [7:0]  RST_CFG_BYTE     = 8'hBF;

  // Fixed read values, write masks and the idle count limit
  localparam logic [15:0] BASIC_STATUS_FIXED = 16'h7949;
  localparam logic [15:0] EXT_STATUS_VALUE   = 16'h3000;
  localparam logic [15:0] EXPANSION_FIXED    = 16'h0064;
  localparam logic [15:0] ADVERTISE_WMASK    = 16'hADFF;
  localparam logic [15:0] NP_TRANSMIT_WMASK  = 16'hB7FF;
  localparam logic [15:0] GIG_CONTROL_WMASK  = 16'hFF00;
  localparam logic [7:0]  CFG_FORCED_ONES    = 8'h80;
  localparam logic [7:0]  IDLE_COUNT_MAX     = 8'hFF;

  // Field positions
  localparam int CTL_SOFT_RESET  = 15;
  localparam int CTL_AN_ENABLE   = 12;
  localparam int CTL_AN_RESTART  = 9;
  localparam int ADV_NEXT_PAGE   = 15;
  localparam int ADV_ASYM_PAUSE  = 11;
  localparam int ADV_PAUSE       = 10;
  localparam int NP_TOGGLE       = 11;
  localparam int GIG_TEST_MSB    = 15;
  localparam int GIG_TEST_LSB    = 13;
  localparam int GIG_MANUAL_EN   = 12;
  localparam int GIG_MANUAL_MST  = 11;
  localparam int GIG_MULTIPORT   = 10;
  localparam int GIG_ADV_FULL    = 9;
  localparam int GIG_ADV_HALF    = 8;
  localparam int CFG_CLK_SOURCE  = 0;
  localparam int CFG_CLK_OUT_DIS = 2;
  localparam int RECOV_ENABLE    = 4;

  // Speed and duplex codes in the auxiliary status
  localparam logic [2:0] SPD_NO_LINK = 3'h0;
  localparam logic [2:0] SPD_10_HALF = 3'h1;
  localparam logic [2:0] SPD_10_FULL = 3'h2;
  localparam logic [2:0] SPD_100_HALF = 3'h3;
  localparam logic [2:0] SPD_100_FULL = 3'h4;
  localparam logic [2:0] SPD_1000_FULL = 3'h7;

  // Line speed as reported by the PHY core
  typedef enum logic [1:0] {
    SPEED_10   = 2'h0,
    SPEED_100  = 2'h1,
    SPEED_1000 = 2'h2
  } line_speed_t;

  // Transmitter test modes
  typedef enum logic [2:0] {
    TEST_NORMAL    = 3'h0,
    TEST_WAVEFORM  = 3'h1,
    TEST_MST_JITTER = 3'h2,
    TEST_SLV_JITTER = 3'h3,
    TEST_DISTORTION = 3'h4
  } test_mode_t;

  // Register access request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } reg_req_t;

  // Live status from the PHY core, same clock domain
  typedef struct packed {
    logic        link_up;
    logic        an_complete;
    logic        remote_fault;
    logic        jabber;
    logic        par_det_fault;
    logic        partner_an_able;
    logic        local_rx_ok;
    logic        remote_rx_ok;
    logic        ms_fault;
    logic        master_resolved;
    line_speed_t speed;
    logic        full_duplex;
    logic        partner_gig_full_ability;
    logic        partner_gig_half_ability;
    logic        idle_error;
    logic        base_page_valid;
    logic [15:0] base_page;
    logic        next_page_valid;
    logic [15:0] next_page;
    logic        next_page_sent;
  } phy_status_t;

  // Controls handed to the PHY core
  typedef struct packed {
    logic       soft_reset;
    logic       an_restart;
    logic       an_enable;
    logic       role_manual;
    logic       role_master;
    logic       multiport;
    test_mode_t test_mode;
    logic       rx_pause;
    logic       tx_pause;
  } phy_control_t;

  // Synchronous clock steering
  typedef struct packed {
    logic prc_select;
    logic clock_out_enable;
    logic from_partner;
  } clock_steer_t;

endpackage

/* File: test_copper_phy_mgmt_registers.sv */
// Self-checking bench for the PHY management register bank
module test_copper_phy_mgmt_registers;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] ID_HIGH = 16'hA5C3; // Arbitrary value
  localparam logic [15:0] ID_LOW  = {6'h1B, 6'h2D, 4'h6}; // Arbitrary value
  logic                       mclk_in = 1'b0;
  logic                       sys_rst_in = 1'b1;
  logic                       ce_in = 1'b1;
  phy_mgmt_pkg::reg_req_t     req;
  logic [15:0]                rdata, d, pg;
  logic                       rvalid, cfg_wr;
  logic [7:0]                 cfg_b, cfg_q;
  phy_mgmt_pkg::phy_status_t  st = '0;
  phy_mgmt_pkg::phy_control_t ctl;
  phy_mgmt_pkg::clock_steer_t stc;
  int                         num_errors = 0, checks = 0, seed = 22, n;
  always #5 mclk_in = ~mclk_in;
  copper_phy_mgmt_registers #(.ID_HIGH(ID_HIGH), .ID_ORG(6'h1B), .ID_MODEL(6'h2D),
    .ID_REV(4'h6)) i_dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in),
    .reg_req_in(req), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .cfg_wr_in(cfg_wr),
    .cfg_byte_in(cfg_b), .cfg_byte_out(cfg_q), .status_in(st), .control_out(ctl),
    .clock_steer_out(stc));
  phy_host_model i_host (.mclk_in(mclk_in), .reg_rdata_in(rdata), .reg_rvalid_in(rvalid),
    .reg_req_out(req), .cfg_wr_out(cfg_wr), .cfg_byte_out(cfg_b));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] r;
    i_host.rd(a, r);
    chk(r, exp);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  function automatic logic [2:0] spd(phy_mgmt_pkg::phy_status_t s);
    if (!s.link_up) return 3'h0;
    if (s.speed == phy_mgmt_pkg::SPEED_1000) return 3'h7;
    return (s.speed == phy_mgmt_pkg::SPEED_100 ? 3'h3 : 3'h1) + {2'h0, s.full_duplex};
  endfunction
  // Watchdog far past the run
  initial begin
    #300us;
    num_errors++;
    stop_test();
  end
  initial begin
    repeat (20) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    // Reset values, unmapped address last
    rchk(5'h01, 16'h7949);
    rchk(5'h02, ID_HIGH);
    rchk(5'h03, ID_LOW);
    rchk(5'h04, 16'h01E1);
    rchk(5'h05, 16'h0000);
    rchk(5'h06, 16'h0064);
    rchk(5'h07, 16'h2001);
    rchk(5'h08, 16'h0000);
    rchk(5'h09, 16'h0200);
    rchk(5'h0A, 16'h0000);
    rchk(5'h19, 16'h0000);
    rchk(5'h1F, 16'h0000);
    // Random writes, each test code twice
    for (int i = 0; i < 16; i++) begin
      d = {i[2:0], 13'($random(seed))};
      i_host.wr(5'h04, d);
      rchk(5'h04, d & 16'hADFF);
      i_host.wr(5'h09, d);
      rchk(5'h09, d & 16'hFF00);
      chk(16'(ctl.test_mode), 16'(d[15:13] > 3'h4 ? 3'h0 : d[15:13]));
      chk(16'({ctl.role_manual, ctl.multiport}), 16'({d[12], d[10]}));
      if (d[12]) chk(16'(ctl.role_master), 16'(d[11]));
      i_host.wr(5'h07, d);
      rchk(5'h07, d & 16'hB7FF);
      i_host.wr(5'h0F, d);
      rchk(5'h0F, 16'h3000);
    end
    // Base page; an expansion read clears page-received
    pg = 16'($random(seed));
    @(posedge mclk_in);
    st.base_page_valid <= 1'b1;
    st.base_page <= pg;
    @(posedge mclk_in);
    st.base_page_valid <= 1'b0;
    rchk(5'h05, pg);
    rchk(5'h06, 16'h0066 | {12'h0, pg[15], 3'h0});
    rchk(5'h06, 16'h0064 | {12'h0, pg[15], 3'h0});
    // Random live status against basic, gigabit and auxiliary views
    i_host.sync_slave();
    chk(16'({cfg_q, stc.clock_out_enable}), {7'h0, 8'hBB, 1'b1});
    i_host.wr(5'h04, 16'h0DE1);
    repeat (32) begin
      d = 16'($random(seed));
      @(posedge mclk_in);
      {st.link_up, st.an_complete, st.remote_fault, st.jabber, st.par_det_fault,
        st.partner_an_able, st.local_rx_ok, st.remote_rx_ok, st.ms_fault,
        st.master_resolved, st.full_duplex, st.partner_gig_full_ability,
        st.partner_gig_half_ability} <= d[12:0];
      st.speed <= d[14] ? phy_mgmt_pkg::SPEED_1000 : phy_mgmt_pkg::line_speed_t'({1'b0, d[13]});
      #1;
      rchk(5'h01, 16'h7949 | {st.an_complete, st.remote_fault, 1'b0, st.link_up, st.jabber,
        1'b0});
      rchk(5'h0A, {st.ms_fault, st.master_resolved, st.local_rx_ok, st.remote_rx_ok,
        st.partner_gig_full_ability, st.partner_gig_half_ability, 10'h0});
      i_host.rd(5'h19, d);
      chk(d & 16'h87FF, {st.an_complete, 4'h0, spd(st), st.par_det_fault, pg[13], 1'b0,
        st.partner_an_able, pg[15], st.link_up,
        {2{st.link_up & st.full_duplex}} & {pg[11] | pg[10], pg[10]}});
      chk(16'(stc.from_partner), 16'(st.link_up && !st.master_resolved &&
        st.speed == phy_mgmt_pkg::SPEED_1000));
    end
    i_host.sync_master();
    chk(16'({cfg_q, stc.prc_select}), {7'h0, 8'hFE, 1'b1});
    rchk(5'h00, 16'h1140);
    // Next-page exchanges flip the transmit toggle
    i_host.wr(5'h07, 16'hFFFF);
    for (int k = 0; k < 2; k++) begin
      d = 16'($random(seed));
      @(posedge mclk_in);
      {st.next_page_valid, st.next_page_sent, st.next_page} <= {2'h3, d};
      @(posedge mclk_in);
      {st.next_page_valid, st.next_page_sent} <= 2'h0;
      rchk(5'h08, d);
      rchk(5'h07, k ? 16'hB7FF : 16'hBFFF);
    end
    // Idle errors count since last read and stick at the top
    for (int k = 0; k < 2; k++) begin
      n = k ? 300 : 2 + ($random(seed) & 63);
      @(posedge mclk_in);
      st <= '0;
      st.idle_error <= 1'b1;
      repeat (n) @(posedge mclk_in);
      st.idle_error <= 1'b0;
      rchk(5'h0A, n > 255 ? 16'h00FF : 16'(n));
      rchk(5'h0A, 16'h0000);
    end
    stop_test();
  end
endmodule
